// ---- rtc_cmos.sv ----
// Clock status registers and indexed configuration RAM behind two ports
//
// Summary of operation
// - Periodic event sets flag bit 6 of the interrupt flag register.
// - Alarm event sets flag bit 5 of the interrupt flag register.
// - Update-ended event sets flag bit 4 of the interrupt flag register.
// - Bit 7 summarises a pending interrupt; bits 6 to 4 give its types.
// - Control bits 6, 5, 4 enable the three interrupts; flag bits 3-0 zero.
// - Power-valid bit 7 is read-only and follows the power-sense input.
// - Floppy byte: first drive upper nibble, second lower; fixed codes.
// - Byte 011 holds first hard disk type; 00 means none.
// - Byte 012 holds second hard disk type; 00 means none.
// - Equipment bits 7,6 give floppy count: 00 one, 01 two.
// - Equipment bits 5,4 give display mode: 01, 10, 11.
// - Equipment bit 1 coprocessor present, bit 0 floppy present.
// - Bytes 015/016 hold base memory 1KB block count, low first.
// - Bytes 017/018 hold expansion memory 1KB block count.
// - CRC over 010 to 031 stored high at 032, low at 033.
// - Bytes 035/036 hold usable memory above 1MB, 1KB blocks.
// - Byte 037 holds the century as two BCD digits.
// - Index port bits 5-0 select the byte the data port reaches.
`timescale 1ns/1ns
module rtc_cmos
	import rtc_cmos_pkg::*;
#(
	parameter int RAM_WORDS = RAM_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Host port access, one-cycle strobes
	input wire logic host_sel,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata,
	// Time-base events, one-cycle pulses from the counter logic
	input wire logic periodic_evt,
	input wire logic alarm_evt,
	input wire logic update_evt,
	// Battery power sense pin
	input wire logic power_sense,
	// Interrupt request and control bits for the time base
	output logic irq,
	output logic [DATA_W-1:0] ctrl_out,
	output logic nmi_mask
);
	import rtc_cmos_pkg::*;

	// The index port reaches exactly the full index space
	if (RAM_WORDS != RAM_DEPTH) begin
		$error("RAM_WORDS must equal the 64-byte index space");
	end

	////////////////////////////////////////////////////////////////////////
	logic [ADDR_W-1:0] index_r;
	logic nmi_mask_r;
	logic [DATA_W-1:0] ctrl_r;
	logic [2:0] flags_r;
	logic [DATA_W-1:0] ram_r [RAM_WORDS];
	logic [DATA_W-1:0] rdata_r;
	logic [2:0] sense_sync_r;
	logic power_ok_r;
	logic irq_r;

	logic wr_index;
	logic wr_data;
	logic rd_data;
	logic [2:0] evt_in;
	logic [2:0] flags_nxt;
	logic flag_read;
	logic pending;

	assign wr_index = host_wr && host_sel == PORT_INDEX;
	assign wr_data = host_wr && host_sel == PORT_DATA;
	assign rd_data = host_rd && host_sel == PORT_DATA;
	assign flag_read = rd_data && index_r == IDX_INTERRUPT_FLAGS;
	// Flag order is {periodic, alarm, update-ended}
	assign evt_in = {periodic_evt, alarm_evt, update_evt};

	// Set wins over the read-clear so an event in the read cycle survives
	always_comb begin
		flags_nxt = flags_r;
		if (flag_read)
			flags_nxt = 3'h0;
		flags_nxt = flags_nxt | evt_in;
	end

	// Gated summary of pending enabled sources
	assign pending = |(flags_r & ctrl_r[BIT_PF:BIT_UF]);

	////////////////////////////////////////////////////////////////////////
	// Index port; NMI mask sits on bit 7 and powers up masked
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			index_r <= IDX_POWER_VALID_STATUS;
			nmi_mask_r <= 1'b1;
		end else if (wr_index) begin
			index_r <= host_wdata[ADDR_W-1:0] & IDX_W;
			nmi_mask_r <= host_wdata[DATA_W-1];
		end
	end

	// Interrupt enable control byte
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			ctrl_r <= CTRL_RESET;
		else if (wr_data && index_r == IDX_CTRL)
			ctrl_r <= host_wdata;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			flags_r <= 3'h0;
		else
			flags_r <= flags_nxt;
	end

	// Request drops in the cycle after the flag read
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= |(flags_nxt & ctrl_r[BIT_PF:BIT_UF]);
	end

	// Power-sense pin: three stages, change taken once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sense_sync_r <= 3'h0;
			power_ok_r <= 1'b0;
		end else begin
			sense_sync_r <= {sense_sync_r[1:0], power_sense};
			if (sense_sync_r[1] == sense_sync_r[2])
				power_ok_r <= sense_sync_r[2];
		end
	end

	// Configuration RAM keeps its content over a system reset, as battery RAM
	// would; the diagnostic and configuration bytes are plain storage here
	always_ff @(posedge core_clk) begin
		if (wr_data && index_r > IDX_POWER_VALID_STATUS)
			ram_r[index_r] <= host_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data is captured on the data-port read strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rdata_r <= BYTE_ZERO;
		else if (rd_data) begin
			if (index_r == IDX_INTERRUPT_FLAGS)
				rdata_r <= {pending, flags_r, 4'h0};
			else if (index_r == IDX_POWER_VALID_STATUS)
				rdata_r <= {power_ok_r, 7'h00};
			else if (index_r == IDX_CTRL)
				rdata_r <= ctrl_r;
			else if (index_r < IDX_CTRL)
				rdata_r <= BYTE_ZERO;
			else
				rdata_r <= ram_r[index_r];
		end
	end

	assign host_rdata = rdata_r;
	assign irq = irq_r;
	assign ctrl_out = ctrl_r;
	assign nmi_mask = nmi_mask_r;
endmodule

// ---- rtc_cmos_pkg.sv ----
// Constants for the clock status registers and configuration RAM map
package rtc_cmos_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int RAM_DEPTH = 64;
	// Host port selects
	localparam logic PORT_INDEX = 1'h0;
	localparam logic PORT_DATA = 1'h1;
	localparam logic [5:0] IDX_W = 6'h3F;
	// Register indices
	localparam logic [5:0] IDX_CTRL = 6'h0B;
	localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h0C;
	localparam logic [5:0] IDX_POWER_VALID_STATUS = 6'h0D;
	localparam logic [5:0] IDX_DIAGNOSTIC_STATUS = 6'h0E;
	localparam logic [5:0] IDX_SHUTDOWN_STATUS = 6'h0F;
	localparam logic [5:0] IDX_FLOPPY_TYPE = 6'h10;
	localparam logic [5:0] IDX_FIRST_HARD_DISK_TYPE = 6'h11;
	localparam logic [5:0] IDX_SECOND_HARD_DISK_TYPE = 6'h12;
	localparam logic [5:0] IDX_RESERVED_13 = 6'h13;
	localparam logic [5:0] IDX_EQUIPMENT_CONFIG = 6'h14;
	localparam logic [5:0] IDX_BASE_MEMORY_LOW = 6'h15;
	localparam logic [5:0] IDX_BASE_MEMORY_HIGH = 6'h16;
	localparam logic [5:0] IDX_EXPANSION_MEMORY_LOW = 6'h17;
	localparam logic [5:0] IDX_EXPANSION_MEMORY_HIGH = 6'h18;
	localparam logic [5:0] IDX_CRC_FIRST = 6'h10;
	localparam logic [5:0] IDX_CRC_LAST = 6'h31;
	localparam logic [5:0] IDX_CONFIG_CRC_HIGH = 6'h32;
	localparam logic [5:0] IDX_CONFIG_CRC_LOW = 6'h33;
	localparam logic [5:0] IDX_RESERVED_34 = 6'h34;
	localparam logic [5:0] IDX_USABLE_MEMORY_LOW = 6'h35;
	localparam logic [5:0] IDX_USABLE_MEMORY_HIGH = 6'h36;
	localparam logic [5:0] IDX_CENTURY_BCD = 6'h37;
	// Interrupt flag and control bit positions
	localparam int BIT_IRQF = 7;
	localparam int BIT_PF = 6;
	localparam int BIT_AF = 5;
	localparam int BIT_UF = 4;
	localparam int BIT_PWR_VALID = 7;
	localparam logic [7:0] FLAG_EVENT_MASK = 8'h70;
	localparam logic [7:0] CTRL_RESET = 8'h02;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Configuration field encodings
	localparam logic [3:0] FLOPPY_NONE = 4'h0;
	localparam logic [3:0] FLOPPY_360K = 4'h1;
	localparam logic [3:0] FLOPPY_720K = 4'h3;
	localparam logic [3:0] FLOPPY_1M44 = 4'h4;
	localparam logic [7:0] HARD_DISK_NONE = 8'h00;
	localparam logic [1:0] FLOPPY_COUNT_ONE = 2'h0;
	localparam logic [1:0] FLOPPY_COUNT_TWO = 2'h1;
	localparam logic [1:0] DISPLAY_40COL = 2'h1;
	localparam logic [1:0] DISPLAY_80COL = 2'h2;
	localparam logic [1:0] DISPLAY_MONO = 2'h3;
	localparam int DIAG_LOST_POWER = 7;
	localparam int DIAG_BAD_CHECKSUM = 6;
	localparam int DIAG_BAD_EQUIPMENT = 5;
	localparam int DIAG_MEM_MISCOMPARE = 4;
	localparam int DIAG_DRIVE_C_FAIL = 3;
	localparam int DIAG_TIME_INVALID = 2;
	localparam int DIAG_ADAPTER_MISMATCH = 1;
	localparam int DIAG_ADAPTER_TIMEOUT = 0;
endpackage

// ---- rtc_cmos_host.sv ----
// Host processor model for the index and data ports
`timescale 1ns/1ns
module rtc_cmos_host
	import rtc_cmos_pkg::*;
(
	// Clock and read data
	input wire logic core_clk,
	input wire logic [DATA_W-1:0] host_rdata,
	// Port strobes
	output logic host_sel,
	output logic host_wr,
	output logic host_rd,
	output logic [DATA_W-1:0] host_wdata
);
	initial begin
		host_sel = PORT_INDEX;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'hA5;
	end
	// Data access follows the index write at once, never split
	task automatic access(input logic [7:0] ix, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		host_sel <= PORT_INDEX;
		host_wr <= 1'b1;
		host_wdata <= ix;
		@(posedge core_clk);
		host_sel <= PORT_DATA;
		host_wr <= wr;
		host_rd <= !wr;
		host_wdata <= d;
		@(posedge core_clk);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		// Released bus must not keep showing the last byte
		host_wdata <= ~d;
		#1 q = host_rdata;
	endtask
endmodule

// ---- rtc_cmos_chk.sv ----
// Port checker for the clock status and interrupt behaviour
`timescale 1ns/1ns
module rtc_cmos_chk
	import rtc_cmos_pkg::*;
(
	// Clock, reset and host port
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic host_sel,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	input wire logic [DATA_W-1:0] host_rdata,
	// Events, power and interrupt
	input wire logic periodic_evt,
	input wire logic alarm_evt,
	input wire logic update_evt,
	input wire logic power_sense,
	input wire logic irq,
	input wire logic [DATA_W-1:0] ctrl_out
);
	logic [5:0] idx_r;
	logic rd_flags, rd_pwr;
	always_ff @(posedge core_clk) begin
		if (!rst_n) idx_r <= IDX_POWER_VALID_STATUS;
		else if (host_wr && !host_sel) idx_r <= host_wdata[5:0];
	end
	assign rd_flags = host_rd && host_sel && idx_r == IDX_INTERRUPT_FLAGS;
	assign rd_pwr = host_rd && host_sel && idx_r == IDX_POWER_VALID_STATUS;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	property p_per; periodic_evt && ctrl_out[BIT_PF] |=> irq; endproperty
	a_per: assert property (p_per) else $error("periodic irq missing");
	property p_alm; alarm_evt && ctrl_out[BIT_AF] |=> irq; endproperty
	a_alm: assert property (p_alm) else $error("alarm irq missing");
	property p_upd; update_evt && ctrl_out[BIT_UF] |=> irq; endproperty
	a_upd: assert property (p_upd) else $error("update irq missing");
	property p_sum; rd_flags |=>
		host_rdata[7] == |(host_rdata[6:4] & $past(ctrl_out[6:4])); endproperty
	a_sum: assert property (p_sum) else $error("summary bit wrong");
	property p_rsv; rd_flags |=> host_rdata[3:0] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("flag low bits set");
	property p_pwr; $stable(power_sense) [*6] ##0 rd_pwr |=>
		host_rdata == {$past(power_sense), 7'h00}; endproperty
	a_pwr: assert property (p_pwr) else $error("power bit wrong");
	property p_clr; rd_flags && !periodic_evt && !alarm_evt && !update_evt
		|=> !irq; endproperty
	a_clr: assert property (p_clr) else $error("irq kept after read");
	property p_off; (ctrl_out[6:4] == 3'h0) [*2] |-> !irq; endproperty
	a_off: assert property (p_off) else $error("irq without enable");
endmodule
bind rtc_cmos rtc_cmos_chk i_chk (.core_clk, .rst_n, .host_sel, .host_wr,
	.host_rd, .host_wdata, .host_rdata, .periodic_evt, .alarm_evt,
	.update_evt, .power_sense, .irq, .ctrl_out);

// ---- tb_rtc_cmos.sv ----
// Self-checking testbench for the clock status and configuration ports
`timescale 1ns/1ns
module tb_rtc_cmos;
	import rtc_cmos_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_sel, host_wr, host_rd, irq, nmi_mask;
	logic [7:0] host_wdata, host_rdata, ctrl_out, q;
	logic periodic_evt = 1'b0;
	logic alarm_evt = 1'b0;
	logic update_evt = 1'b0;
	logic power_sense = 1'b1;
	int bad_count = 0;
	int checked = 0;
	logic [7:0] c_ix [8] = '{8'h8E, 8'h90, 8'h91, 8'h92, 8'h94, 8'h96,
		8'hB3, 8'hB7};
	logic [7:0] c_val [8] = '{8'h84, 8'h41, 8'h00, 8'h2F, 8'h63, 8'h02,
		8'h5A, 8'h20};
	always #50 core_clk = ~core_clk;
	rtc_cmos i_dut (.core_clk, .rst_n, .host_sel, .host_wr, .host_rd,
		.host_wdata, .host_rdata, .periodic_evt, .alarm_evt, .update_evt,
		.power_sense, .irq, .ctrl_out, .nmi_mask);
	rtc_cmos_host i_host (.core_clk, .host_rdata, .host_sel, .host_wr,
		.host_rd, .host_wdata);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] ix, d);
		i_host.access(ix, 1'b1, d, q);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] ix, e);
		i_host.access(ix, 1'b0, 8'h00, q);
		chk(nm, q, e);
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge core_clk);
		{periodic_evt, alarm_evt, update_evt} <= m;
		@(posedge core_clk);
		{periodic_evt, alarm_evt, update_evt} <= 3'h0;
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("ctrl reset", ctrl_out, CTRL_RESET);
		chk("nmi reset", {7'h0, nmi_mask}, 8'h01);
		rd_chk("power good", 8'h8D, 8'h80);
		@(posedge core_clk) power_sense <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd_chk("power lost", 8'h8D, 8'h00);
		$display("test power done");
		for (int i = 0; i < 8; i++) begin
			wr(c_ix[i], c_val[i]);
		end
		for (int i = 0; i < 8; i++) begin
			rd_chk("cfg", c_ix[i], c_val[i]);
		end
		$display("test config done");
		// Index written without bit 7 unmasks the NMI
		wr(8'h0B, 8'h70);
		chk("nmi clear", {7'h0, nmi_mask}, 8'h00);
		chk("ctrl", ctrl_out, 8'h70);
		// Flag register is read-only; this write must leave no trace
		wr(8'h8C, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			pulse(3'h4 >> i);
			chk("irq set", {7'h0, irq}, 8'h01);
			rd_chk("flags", 8'h8C, 8'h80 | (8'h40 >> i));
			chk("irq clear", {7'h0, irq}, 8'h00);
		end
		wr(8'h8B, 8'h20);
		chk("nmi set", {7'h0, nmi_mask}, 8'h01);
		pulse(3'h5);
		chk("irq masked", {7'h0, irq}, 8'h00);
		rd_chk("masked flags", 8'h8C, 8'h50);
		rd_chk("flags empty", 8'h8C, 8'h00);
		$display("test interrupts done");
		stop_test;
	end
	// Tests need about 125 cycles; this allows about five thousand
	initial begin
		#500000;
		bad_count++;
		stop_test;
	end
endmodule
